// >>> dv/mm_master_model.sv
module mm_master_model
  import mm_lane_pkg::*;
(
  input wire logic core_clk,
  output logic [7:0] address,
  output xfer_s xfer,
  output logic [3:0] lane_en_n,
  output logic [31:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    address = 8'h00;
    xfer = '0;
    lane_en_n = 4'hF;
    wr_data = 32'h0;
  end
  // an aligned word index, as the interconnect converts it from bytes
  // lanes always driven, active low, only the lanes of the given pattern set
  task automatic issue(input logic w, r, input logic [7:0] a, input logic [3:0] on, input logic [31:0] d);
    @(posedge core_clk) #1;
    xfer = '{wr: w, rd: r};
    address = a;
    lane_en_n = ~on;
    wr_data = d;
  endtask
  // released address and write data show inverted values so stale data cannot pass for valid; the lanes keep their pattern
  task automatic idle();
    @(posedge core_clk) #1;
    xfer = '0;
    address = ~address;
    wr_data = ~wr_data;
  endtask
endmodule

// >>> dv/mm_slave_address_byte_lanes_tb_top.sv
module mm_slave_address_byte_lanes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mm_lane_pkg::*;
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
  typedef struct packed {logic r; logic w; fault_s f; logic [31:0] d;} note_s;
  logic core_clk = 0;
  logic nrst = 0;
  logic [7:0] address;
  xfer_s xfer;
  logic [3:0] lane_en_n;
  logic [31:0] wr_data;
  logic [31:0] rd_data_q;
  logic rd_done_q;
  logic wr_done_q;
  fault_s fault_q;
  note_s q[$];
  logic [31:0] mem [16];
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [3:0] pat [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  logic [3:0] bad [4] = '{4'h0, 4'h5, 4'h6, 4'h9};
  mm_master_model u_mst (.core_clk, .address, .xfer, .lane_en_n, .wr_data);
  mm_word_slave u_dut (.core_clk, .nrst, .address, .xfer, .lane_en_n, .wr_data,
    .rd_data_q, .rd_done_q, .wr_done_q, .fault_q);
  initial
    forever #2.5 core_clk = ~core_clk;
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // note the expected answer, update the reference word, then send the request
  task automatic xf(input logic w, r, input logic [7:0] a, input logic [3:0] on, input logic [31:0] d);
    note_s n;
    n.r = r;
    n.w = w && a < 16;
    n.f = '{lane_illegal: w && !(on inside {pat}), misaligned: 1'b0, out_of_range: a > 15};
    n.d = r && a < 16 ? mem[a] : 32'h0;
    if (r || n.w)
      q.push_back(n);
    for (int i = 0; i < 4; i++)
      if (n.w && on[i])
        mem[a][8*i +: 8] = d[8*i +: 8];
    u_mst.issue(w, r, a, on, d);
  endtask
  always @(negedge core_clk)
    if (rd_done_q === 1'b1 || wr_done_q === 1'b1)
    begin
      note_s n;
      n = q.size() ? q.pop_front() : '0;
      `CHK({rd_done_q, wr_done_q, fault_q, rd_done_q ? rd_data_q : 32'h0}, n)
    end
  // cut a hang short; the run needs about 113 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'h6b7b5c3e));
    mem = '{default: 32'h0};
    repeat (8) @(posedge core_clk);
    #1 nrst = 1;
    for (int i = 0; i < 16; i++)
      xf(0, 1, 8'(i), 4'hF, 0);
    u_mst.idle();
    for (int k = 0; k < 60; k++)
      xf(1'($urandom_range(1)), 1'($urandom_range(1)), 8'($urandom_range(15)), pat[$urandom_range(6)],
        $urandom);
    foreach (bad[j])
      xf(1, 0, 8'(j), bad[j], $urandom);
    xf(1, 0, 8'h05, 4'h3, $urandom);
    xf(0, 1, 8'h05, 4'hC, 0);
    xf(1, 0, 8'h10, 4'hF, $urandom);
    xf(1, 1, 8'hFF, 4'hF, $urandom);
    for (int i = 0; i < 16; i++)
      xf(0, 1, 8'(i), 4'h1, 0);
    u_mst.idle();
    repeat (3) @(posedge core_clk);
    `CHK(q.size(), 0)
    results();
  end
endmodule

// >>> dv/mm_word_slave_monitor.sv
module mm_word_slave_monitor
  import mm_lane_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8,
  parameter int DEPTH = 16,
  parameter int LANES = 4
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire xfer_s xfer,
  input wire logic [LANES-1:0] lane_en_n,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] rd_data_q,
  input wire logic rd_done_q,
  input wire logic wr_done_q,
  input wire fault_s fault_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [DATA_W-1:0] m;
  wire [3:0] lon = 4'(~lane_en_n);
  wire ok = lon inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  wire hit = address < DEPTH;
  // bit mask of the enabled byte lanes
  always_comb
    for (int i = 0; i < DATA_W; i++)
      m[i] = ~lane_en_n[i/BYTE_W];
  property p_rd; xfer.rd |=> rd_done_q; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_hold; !xfer.rd |=> !rd_done_q && $stable(rd_data_q); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wr; xfer.wr && hit |=> wr_done_q; endproperty
  a_wr: assert property (p_wr) else $error("write not done");
  property p_oor; xfer.wr && !hit |=> !wr_done_q && fault_q.out_of_range; endproperty
  a_oor: assert property (p_oor) else $error("range write taken");
  property p_lane;
    xfer.wr && hit ##1 xfer.rd && address == $past(address) |=>
      (rd_data_q & $past(m, 2)) == ($past(wr_data, 2) & $past(m, 2));
  endproperty
  a_lane: assert property (p_lane) else $error("lane data wrong");
  property p_rzero; xfer.rd && !hit |=> rd_data_q == '0 && fault_q.out_of_range; endproperty
  a_rzero: assert property (p_rzero) else $error("range read wrong");
  property p_pat; xfer.wr && !xfer.rd |=> fault_q.lane_illegal != $past(ok); endproperty
  a_pat: assert property (p_pat) else $error("lane flag wrong");
  property p_word; xfer.wr || xfer.rd |=> !fault_q.misaligned; endproperty
  a_word: assert property (p_word) else $error("word mode misaligned");
endmodule
bind mm_word_slave mm_word_slave_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .DEPTH(DEPTH), .LANES(LANES)) u_mon
  (.core_clk, .nrst, .address, .xfer, .lane_en_n, .wr_data, .rd_data_q, .rd_done_q, .wr_done_q, .fault_q);

// >>> verilog/lane_qualify.sv
// resolves the active-low lane enables into per-byte strobes and checks the pattern
module lane_qualify
  import mm_lane_pkg::*;
#(
  parameter int LANES = 4,
  parameter bit HAS_LANES = 1'b1
)
(
  input wire logic [LANES-1:0] lane_en_n,
  input wire logic wr_en,
  output logic [LANES-1:0] lanes,
  output logic [LANES-1:0] byte_wr,
  output logic pattern_ok
);

  // true when the set lanes form one aligned, power-of-two sized group
  function automatic logic group_ok(input logic [LANES-1:0] be);
    logic ok;
    logic [LANES-1:0] mask;
    ok = 1'b0;
    for (int s = 1; s <= LANES; s = s * 2)
    begin
      for (int o = 0; o < LANES; o = o + s)
      begin
        mask = '0;
        for (int b = 0; b < s; b++)
        begin
          mask[o + b] = 1'b1;
        end
        if (be == mask)
        begin
          ok = 1'b1;
        end
      end
    end
    return ok;
  endfunction

  wire logic [LANES-1:0] lanes_hi;

  // the pin is active low, so invert once here and use active-high lanes inside
  assign lanes_hi = ~lane_en_n;

  // without a lane vector every transfer is a full word
  assign lanes = HAS_LANES ? lanes_hi : {LANES{1'b1}};

  // an all-zero vector writes nothing and is flagged, not silently accepted
  assign pattern_ok = group_ok(lanes);

  genvar i;
  generate
    for (i = 0; i < LANES; i++)
    begin : g_strobe
      // lane n gates byte n only
      assign byte_wr[i] = wr_en & lanes[i];
    end
  endgenerate

endmodule

// >>> verilog/mm_lane_pkg.sv
package mm_lane_pkg;

  // default geometry of the slave word store
  localparam int DATA_W_DEF = 32;
  localparam int ADDR_W_DEF = 8;
  localparam int DEPTH_DEF = 16;

  // byte lane and legal bus widths
  localparam int BYTE_W = 8;
  localparam int MIN_DATA_W = 8;
  localparam int MAX_DATA_W = 1024;
  localparam int MIN_ADDR_W = 1;
  localparam int MAX_ADDR_W = 64;
  localparam int MAX_LANES = 128;

  // reset contents of one byte of the store and of the read bus
  localparam logic [7:0] MEM_RST_BYTE = 8'h00;

  // reset level of the done pulses
  localparam logic DONE_RST = 1'b0;

  // how the address input is interpreted
  typedef enum logic [1:0]
  {
    GRAN_WORDS = 2'b01,
    GRAN_BYTES = 2'b10
  } address_granularity_setting_e;

  // one request as issued by the interconnect
  typedef struct packed {
    logic wr;
    logic rd;
  } xfer_s;

  // fault flags of the most recent transfer
  typedef struct packed {
    logic lane_illegal;
    logic misaligned;
    logic out_of_range;
  } fault_s;

  localparam fault_s FAULT_NONE = '{lane_illegal: 1'b0, misaligned: 1'b0, out_of_range: 1'b0};

endpackage

// >>> verilog/mm_word_slave.sv
// Function
// - A read-only port needs at least read data and a write-only port needs write data and a write strobe.
// - Any signal may be active high, and one that is active low carries a trailing _n and is read inverted.
// - The slave decodes its address as a word index, zero the first word and one the second, unless set to bytes.
// - Buses wider than eight bits may carry a lane enable vector of 2 to 128 bits, one per data byte.
// - Lane enable bit n qualifies byte n of both the write data and the read data.
// - On a write the slave changes only the enabled bytes and leaves the rest of the word as it was.
// - On a read the lanes show the wanted bytes, and a slave without read side effects may return the full word.
// - Without a lane enable vector every transfer behaves as if all lanes were enabled.
// - The slave answers each read with data on a read bus of 8 to 1024 bits.
module mm_word_slave
  import mm_lane_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DEPTH = DEPTH_DEF,
  parameter bit HAS_LANES = 1'b1,
  parameter address_granularity_setting_e address_granularity_setting = GRAN_WORDS,
  parameter int LANES = DATA_W / BYTE_W
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire xfer_s xfer,
  input wire logic [LANES-1:0] lane_en_n,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data_q,
  output logic rd_done_q,
  output logic wr_done_q,
  output fault_s fault_q
);

  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int OFS_W = (LANES > 1) ? $clog2(LANES) : 0;
  localparam logic [ADDR_W:0] DEPTH_CMP = (ADDR_W + 1)'(DEPTH);

  // widths that the datapath cannot serve are refused at elaboration
  generate
    if (DATA_W < MIN_DATA_W || DATA_W > MAX_DATA_W || (DATA_W & (DATA_W - 1)) != 0)
    begin : g_bad_data
      $error("data width must be a power of two from 8 to 1024");
    end
    if (LANES * BYTE_W != DATA_W || LANES > MAX_LANES)
    begin : g_bad_lanes
      $error("lane count must equal data width over eight");
    end
    if (ADDR_W < MIN_ADDR_W || ADDR_W > MAX_ADDR_W)
    begin : g_bad_addr
      $error("address width must be 1 to 64");
    end
    if (DEPTH < 2 || ADDR_W < IDX_W + ((address_granularity_setting == GRAN_BYTES) ? OFS_W : 0))
    begin : g_bad_depth
      $error("depth must be at least two and reachable by the address");
    end
    // a single-byte bus carries no lane vector, so one lane is refused while lanes are on
    if (HAS_LANES && LANES < 2)
    begin : g_bad_lane_vec
      $error("a lane vector needs a bus wider than one byte");
    end
    // an integer cast into the setting would otherwise fall through to word mode
    if (address_granularity_setting != GRAN_WORDS && address_granularity_setting != GRAN_BYTES)
    begin : g_bad_gran
      $error("address granularity must be words or bytes");
    end
    // the write-only minimum needs both the write strobe and write data, so both are ports
  endgenerate

  logic [DATA_W-1:0] mem_q [DEPTH];

  wire logic [LANES-1:0] lanes;
  wire logic [LANES-1:0] byte_wr;
  wire logic pattern_ok;
  wire logic [ADDR_W-1:0] word_addr;
  wire logic misaligned;
  wire logic in_range;
  wire logic [IDX_W-1:0] idx;
  wire logic wr_go;
  wire logic any_xfer;
  wire fault_s fault_d;
  wire logic [DATA_W-1:0] rd_word;
  wire logic [DATA_W-1:0] rd_data_d;
  wire logic [DEPTH-1:0] word_sel;
  wire logic rd_done_d;
  wire logic wr_done_d;

  generate
    if (address_granularity_setting == GRAN_BYTES && OFS_W > 0)
    begin : g_byte_addr
      // byte addressing: drop the in-word offset, which an aligned master leaves at zero
      assign word_addr = ADDR_W'(address >> OFS_W);
      assign misaligned = |address[OFS_W-1:0];
    end
    else
    begin : g_word_addr
      // the interconnect already hands over a word index: 0 is the first word, 1 the second
      assign word_addr = address;
      assign misaligned = 1'b0;
    end
  endgenerate

  assign in_range = ({1'b0, word_addr} < DEPTH_CMP);
  assign idx = word_addr[IDX_W-1:0];

  // a misaligned or out-of-range write is dropped rather than spilling into a neighbour word
  assign wr_go = xfer.wr & in_range & ~misaligned;

  lane_qualify #(
    .LANES(LANES),
    .HAS_LANES(HAS_LANES)
  ) u_lanes (
    .lane_en_n(lane_en_n),
    .wr_en(wr_go),
    .lanes(lanes),
    .byte_wr(byte_wr),
    .pattern_ok(pattern_ok)
  );

  // reads have no side effects here, so the full word returns whatever the lanes say
  assign rd_word = in_range ? mem_q[idx] : '0;
  assign rd_data_d = (xfer.rd & ~misaligned) ? rd_word : '0;

  assign any_xfer = xfer.wr | xfer.rd;

  // wr_done_q marks taken writes only and rd_done_q every read; with no back-pressure they never stretch
  assign rd_done_d = xfer.rd;
  assign wr_done_d = wr_go;

  // lane pattern checked for both directions; a bad pattern still writes its set lanes
  assign fault_d = '{lane_illegal: ~pattern_ok, misaligned: misaligned, out_of_range: ~in_range};

  genvar w;
  genvar b;
  generate
    for (w = 0; w < DEPTH; w++)
    begin : g_sel
      // gating with the range check keeps a wrapped index from touching a real word
      assign word_sel[w] = in_range & (idx == IDX_W'(w));
    end
  endgenerate

  // clearing the whole store at reset costs area but keeps reads of unwritten words defined
  generate
    for (w = 0; w < DEPTH; w++)
    begin : g_word
      for (b = 0; b < LANES; b++)
      begin : g_byte
        wire logic byte_hit;
        assign byte_hit = byte_wr[b] & word_sel[w];
        // only the strobed byte of the addressed word moves; all others hold
        always_ff @(posedge core_clk or negedge nrst)
        begin
          if (!nrst)
          begin
            mem_q[w][b*BYTE_W +: BYTE_W] <= MEM_RST_BYTE;
          end
          else if (byte_hit)
          begin
            mem_q[w][b*BYTE_W +: BYTE_W] <= wr_data[b*BYTE_W +: BYTE_W];
          end
        end
      end
    end
  endgenerate

  // a read in the same cycle as a write to the same word sees the old contents
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_q <= {LANES{MEM_RST_BYTE}};
    end
    else if (xfer.rd)
    begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_done_q <= DONE_RST;
    end
    else
    begin
      rd_done_q <= rd_done_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_done_q <= DONE_RST;
    end
    else
    begin
      wr_done_q <= wr_done_d;
    end
  end

  // faults describe the latest transfer and hold until the next one
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fault_q <= FAULT_NONE;
    end
    else if (any_xfer)
    begin
      fault_q <= fault_d;
    end
  end

endmodule
